// ---- shared/rhcd_pkg.sv ----
// What this block does
// - Sync byte aligns processor after reset
// - Codes move radio to off, idle, receive
// - Codes move radio to transmit, sleep
// - Apply stored backup configuration to radio
// - Start intermediate-frequency filter calibration
// - Full reset, radio ends in sleep
// - Prepare program memory for module download
// - Restart processor after module download
// - Image calibration only with module resident
// - Crypto module: encrypt, decrypt packet payload
// - Crypto module: initialise decryption variables
// - Coding module: init encoder, append checks
// - Coding module: correct received payload
// - Shared codes follow whichever module resides
// - Sequential write prefix and its targets
// - Eleven-bit address, top bits in command
// - Sequential read prefix and its targets
// - Scattered write prefix and its targets
// - Scattered read prefix and its targets
// - All-ones byte is a no-operation
package rhcd_pkg;

   // ************************************************
   // Command codes
   // ************************************************
   localparam logic [7:0] SYNC_CMD            = 8'ha2;
   localparam logic [7:0] GO_OFF_CMD          = 8'hb0;
   localparam logic [7:0] GO_IDLE_CMD         = 8'hb1;
   localparam logic [7:0] GO_RECEIVE_CMD      = 8'hb2;
   localparam logic [7:0] GO_TRANSMIT_CMD     = 8'hb5;
   localparam logic [7:0] GO_SLEEP_CMD        = 8'hba;
   localparam logic [7:0] APPLY_CONFIG_CMD    = 8'hbb;
   localparam logic [7:0] SIGNAL_STRENGTH_CMD = 8'hbc;
   localparam logic [7:0] IMAGE_CAL_CMD       = 8'hbd;
   localparam logic [7:0] IF_FILTER_CAL_CMD   = 8'hbe;
   localparam logic [7:0] LOAD_INIT_CMD       = 8'hbf;
   localparam logic [7:0] LOAD_DONE_CMD       = 8'hc7;
   localparam logic [7:0] FULL_RESET_CMD      = 8'hc8;
   localparam logic [7:0] MODULE_OP0_CMD      = 8'hd0;
   localparam logic [7:0] MODULE_OP1_CMD      = 8'hd1;
   localparam logic [7:0] MODULE_OP2_CMD      = 8'hd2;
   localparam logic [7:0] NO_OP_BYTE          = 8'hff;

   // ************************************************
   // Memory command prefixes, upper five bits
   // ************************************************
   localparam int         PFX_LSB        = 3;
   localparam logic [4:0] SEQ_WRITE_PFX  = 5'h03;
   localparam logic [4:0] SEQ_READ_PFX   = 5'h07;
   localparam logic [4:0] SCATTER_WR_PFX = 5'h01;
   localparam logic [4:0] SCATTER_RD_PFX = 5'h05;
   localparam int         ADDR_W         = 11;
   localparam int         ADDR_HI_W      = 3;
   localparam logic [ADDR_W-1:0] ADDR_STEP = 11'h001;

   // ************************************************
   // Types
   // ************************************************
   typedef enum logic [2:0] {
      off_state      = 3'h0,
      idle_state     = 3'h1,
      receive_state  = 3'h2,
      transmit_state = 3'h3,
      sleep_state    = 3'h4
   } rhcd_radio_t;

   localparam rhcd_radio_t RADIO_RESET = sleep_state;

   typedef enum logic [4:0] {
      K_NONE     = 5'h00,
      K_SYNC     = 5'h01,
      K_OFF      = 5'h02,
      K_IDLE     = 5'h03,
      K_RX       = 5'h04,
      K_TX       = 5'h05,
      K_SLEEP    = 5'h06,
      K_CONFIG   = 5'h07,
      K_RSSI     = 5'h08,
      K_IFCAL    = 5'h09,
      K_HWRST    = 5'h0a,
      K_LDINIT   = 5'h0b,
      K_LDDONE   = 5'h0c,
      K_IRCAL    = 5'h0d,
      K_MOD0     = 5'h0e,
      K_MOD1     = 5'h0f,
      K_MOD2     = 5'h10,
      K_SEQ_WR   = 5'h11,
      K_SEQ_RD   = 5'h12,
      K_SCAT_WR  = 5'h13,
      K_SCAT_RD  = 5'h14,
      K_NOP      = 5'h15
   } rhcd_kind_t;

   typedef enum logic [1:0] {
      FW_NONE  = 2'h0,
      FW_IMAGE = 2'h1,
      FW_CRYPT = 2'h2,
      FW_FEC   = 2'h3
   } rhcd_fw_t;

   typedef enum logic [2:0] {
      PH_CMD     = 3'h0,
      PH_SEQ_ADR = 3'h1,
      PH_SEQ_WR  = 3'h2,
      PH_SEQ_RD  = 3'h3,
      PH_SC_ADR  = 3'h4,
      PH_SC_WR   = 3'h5,
      PH_SC_RD   = 3'h6
   } rhcd_phase_t;

endpackage : rhcd_pkg

// ---- rtl/rhcd_cmd_class.sv ----
`timescale 1ns/10ps
`default_nettype none
module rhcd_cmd_class
   import rhcd_pkg::*;
(
   // Byte to classify
   input  wire logic [7:0] cmd_byte,
   // Classification
   output rhcd_kind_t      cmd_kind
);

   logic [4:0] prefix;

   assign prefix = cmd_byte[7:PFX_LSB];

   always_comb begin
      case (cmd_byte)
         SYNC_CMD:            cmd_kind = K_SYNC;
         GO_OFF_CMD:          cmd_kind = K_OFF;
         GO_IDLE_CMD:         cmd_kind = K_IDLE;
         GO_RECEIVE_CMD:      cmd_kind = K_RX;
         GO_TRANSMIT_CMD:     cmd_kind = K_TX;
         GO_SLEEP_CMD:        cmd_kind = K_SLEEP;
         APPLY_CONFIG_CMD:    cmd_kind = K_CONFIG;
         SIGNAL_STRENGTH_CMD: cmd_kind = K_RSSI;
         IF_FILTER_CAL_CMD:   cmd_kind = K_IFCAL;
         FULL_RESET_CMD:      cmd_kind = K_HWRST;
         LOAD_INIT_CMD:       cmd_kind = K_LDINIT;
         LOAD_DONE_CMD:       cmd_kind = K_LDDONE;
         IMAGE_CAL_CMD:       cmd_kind = K_IRCAL;
         MODULE_OP0_CMD:      cmd_kind = K_MOD0;
         MODULE_OP1_CMD:      cmd_kind = K_MOD1;
         MODULE_OP2_CMD:      cmd_kind = K_MOD2;
         NO_OP_BYTE:          cmd_kind = K_NOP;
         default: begin
            if (prefix == SEQ_WRITE_PFX) begin
               cmd_kind = K_SEQ_WR;
            end else if (prefix == SEQ_READ_PFX) begin
               cmd_kind = K_SEQ_RD;
            end else if (prefix == SCATTER_WR_PFX) begin
               cmd_kind = K_SCAT_WR;
            end else if (prefix == SCATTER_RD_PFX) begin
               cmd_kind = K_SCAT_RD;
            end else begin
               cmd_kind = K_NONE;
            end
         end
      endcase
   end

endmodule : rhcd_cmd_class
`default_nettype wire

// ---- rtl/rhcd_decoder.sv ----
`timescale 1ns/10ps
`default_nettype none
module rhcd_decoder
   import rhcd_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   input  wire logic              clk_en,
   // Byte stream from the serial port
   input  wire logic              frame_active,
   input  wire logic              byte_valid,
   input  wire logic [7:0]        byte_in,
   // Reply byte for the next shift
   output logic [7:0]             reply_byte_ff,
   output logic                   reply_valid_ff,
   // Memory port
   output logic [ADDR_W-1:0]      mem_addr_ff,
   output logic [7:0]             mem_wdata_ff,
   output logic                   mem_wr_ff,
   output logic                   mem_rd_ff,
   input  wire logic [7:0]        mem_rdata,
   input  wire logic              mem_rvalid,
   // Firmware module resident in program memory
   input  wire logic [1:0]        resident_module,
   // Radio status
   output rhcd_radio_t            radio_state_ff,
   output logic                   synced_ff,
   // Action strobes
   output logic                   apply_config_ff,
   output logic                   signal_strength_ff,
   output logic                   if_filter_cal_ff,
   output logic                   image_cal_ff,
   output logic                   full_reset_ff,
   output logic                   load_init_ff,
   output logic                   load_done_ff,
   output logic                   encrypt_ff,
   output logic                   decrypt_ff,
   output logic                   decrypt_init_ff,
   output logic                   fec_encode_init_ff,
   output logic                   fec_encode_ff,
   output logic                   fec_decode_ff
);

   // ************************************************
   // Byte classification
   // ************************************************
   rhcd_kind_t  kind;
   rhcd_phase_t phase_ff;
   rhcd_phase_t nxt_phase;
   rhcd_fw_t    fw;
   logic        take;
   logic        cmd_take;
   logic        act;
   logic        mode_rd_ff;

   rhcd_cmd_class u_class (
      .cmd_byte (byte_in),
      .cmd_kind (kind)
   );

   assign fw       = rhcd_fw_t'(resident_module);
   assign take     = clk_en && frame_active && byte_valid;
   assign cmd_take = take && (phase_ff == PH_CMD);
   // Nothing but the sync byte is obeyed until aligned
   assign act      = cmd_take && (synced_ff || kind == K_SYNC);

   // ************************************************
   // Alignment flag
   // ************************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         synced_ff <= 1'b0;
      end else if (act && kind == K_SYNC) begin
         synced_ff <= 1'b1;
      end else if (act && kind == K_HWRST) begin
         synced_ff <= 1'b0;
      end
   end

   // ************************************************
   // Frame phase
   // ************************************************
   // A frame drop on a clk_en cycle returns to command phase, so a
   // truncated transfer cannot swallow the next command.
   always_comb begin
      nxt_phase = phase_ff;
      case (phase_ff)
         PH_CMD: begin
            if (act) begin
               case (kind)
                  K_SEQ_WR, K_SEQ_RD: nxt_phase = PH_SEQ_ADR;
                  K_SCAT_WR:          nxt_phase = PH_SC_ADR;
                  K_SCAT_RD:          nxt_phase = PH_SC_ADR;
                  default:            nxt_phase = PH_CMD;
               endcase
            end
         end
         PH_SEQ_ADR: nxt_phase = mode_rd_ff ? PH_SEQ_RD : PH_SEQ_WR;
         PH_SEQ_WR:  nxt_phase = PH_SEQ_WR;
         PH_SEQ_RD:  nxt_phase = PH_SEQ_RD;
         PH_SC_ADR:  nxt_phase = mode_rd_ff ? PH_SC_RD : PH_SC_WR;
         PH_SC_WR:   nxt_phase = PH_SC_ADR;
         PH_SC_RD:   nxt_phase = PH_SC_ADR;
         default:    nxt_phase = PH_CMD;
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_ff <= PH_CMD;
      end else if (clk_en) begin
         if (!frame_active) begin
            phase_ff <= PH_CMD;
         end else if (byte_valid) begin
            phase_ff <= nxt_phase;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_rd_ff <= 1'b0;
      end else if (act) begin
         mode_rd_ff <= (kind == K_SEQ_RD) || (kind == K_SCAT_RD);
      end
   end

   // ************************************************
   // Address and data path
   // ************************************************
   logic [ADDR_HI_W-1:0] addr_hi_ff;
   logic                 adr_phase;

   assign adr_phase = (phase_ff == PH_SEQ_ADR) || (phase_ff == PH_SC_ADR);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         addr_hi_ff <= '0;
      end else if (act) begin
         addr_hi_ff <= byte_in[ADDR_HI_W-1:0];
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mem_addr_ff <= '0;
      end else if (take && adr_phase) begin
         mem_addr_ff <= {addr_hi_ff, byte_in};
      end else if ((take && phase_ff == PH_SEQ_RD) ||
                   (clk_en && mem_wr_ff && phase_ff == PH_SEQ_WR)) begin
         // Step after the write strobe, so it meets its own address
         mem_addr_ff <= mem_addr_ff + ADDR_STEP;
      end
   end

   // Reads issue in the same cycle the address settles, so
   // the first byte is ready for the first filler byte.
   logic rd_next;

   assign rd_next = take && mode_rd_ff &&
                    (adr_phase || phase_ff == PH_SEQ_RD);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mem_rd_ff <= 1'b0;
      end else if (clk_en) begin
         mem_rd_ff <= rd_next && (phase_ff != PH_SEQ_RD ||
                                  byte_in == NO_OP_BYTE);
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mem_wr_ff    <= 1'b0;
         mem_wdata_ff <= '0;
      end else if (clk_en) begin
         mem_wr_ff <= take && (phase_ff == PH_SEQ_WR ||
                               phase_ff == PH_SC_WR);
         if (take) begin
            mem_wdata_ff <= byte_in;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reply_byte_ff  <= NO_OP_BYTE;
         reply_valid_ff <= 1'b0;
      end else if (clk_en) begin
         reply_valid_ff <= mem_rvalid;
         if (mem_rvalid) begin
            reply_byte_ff <= mem_rdata;
         end
      end
   end

   // ************************************************
   // Radio state
   // ************************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         radio_state_ff <= RADIO_RESET;
      end else if (act) begin
         case (kind)
            K_OFF:   radio_state_ff <= off_state;
            K_IDLE:  radio_state_ff <= idle_state;
            K_RX:    radio_state_ff <= receive_state;
            K_TX:    radio_state_ff <= transmit_state;
            K_SLEEP: radio_state_ff <= sleep_state;
            K_HWRST: radio_state_ff <= sleep_state;
            default: radio_state_ff <= radio_state_ff;
         endcase
      end
   end

   // ************************************************
   // Plain action strobes
   // ************************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         apply_config_ff    <= 1'b0;
         signal_strength_ff <= 1'b0;
         if_filter_cal_ff   <= 1'b0;
         full_reset_ff      <= 1'b0;
         load_init_ff       <= 1'b0;
         load_done_ff       <= 1'b0;
      end else if (clk_en) begin
         apply_config_ff    <= act && kind == K_CONFIG;
         signal_strength_ff <= act && kind == K_RSSI;
         if_filter_cal_ff   <= act && kind == K_IFCAL;
         full_reset_ff      <= act && kind == K_HWRST;
         load_init_ff       <= act && kind == K_LDINIT;
         load_done_ff       <= act && kind == K_LDDONE;
      end
   end

   // ************************************************
   // Module-dependent strobes
   // ************************************************
   // Without the matching module these codes do nothing.
   logic crypt;
   logic fec;

   assign crypt = act && fw == FW_CRYPT;
   assign fec   = act && fw == FW_FEC;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         image_cal_ff       <= 1'b0;
         encrypt_ff         <= 1'b0;
         decrypt_ff         <= 1'b0;
         decrypt_init_ff    <= 1'b0;
         fec_encode_init_ff <= 1'b0;
         fec_encode_ff      <= 1'b0;
         fec_decode_ff      <= 1'b0;
      end else if (clk_en) begin
         image_cal_ff <= act && kind == K_IRCAL &&
                         fw == FW_IMAGE;
         encrypt_ff         <= crypt && kind == K_MOD0;
         decrypt_ff         <= crypt && kind == K_MOD2;
         decrypt_init_ff    <= crypt && kind == K_MOD1;
         fec_encode_init_ff <= fec && kind == K_MOD1;
         fec_encode_ff      <= fec && kind == K_MOD0;
         fec_decode_ff      <= fec && kind == K_MOD2;
      end
   end

endmodule : rhcd_decoder
`default_nettype wire

// ---- tb/rhcd_decoder_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module rhcd_decoder_sva
   import rhcd_pkg::*;
(
   // Clock and reset
   input wire logic              sys_clk,
   input wire logic              sys_rst,
   // Byte stream and memory reply
   input wire logic              clk_en,
   input wire logic              frame_active,
   input wire logic              byte_valid,
   input wire logic [7:0]        byte_in,
   input wire logic [1:0]        resident_module,
   input wire logic              mem_rvalid,
   input wire logic [7:0]        mem_rdata,
   // Design outputs
   input wire rhcd_radio_t       radio_state_ff,
   input wire logic              synced_ff,
   input wire logic [7:0]        reply_byte_ff,
   input wire logic              reply_valid_ff,
   input wire logic [ADDR_W-1:0] mem_addr_ff,
   input wire logic [7:0]        mem_wdata_ff,
   input wire logic              mem_wr_ff,
   input wire logic              mem_rd_ff,
   input wire logic              image_cal_ff,
   input wire logic              full_reset_ff,
   input wire logic              encrypt_ff,
   input wire logic              fec_encode_ff
);
   // ************
   // Phase helper
   // ************
   // A memory command owns the rest of its frame
   logic       in_cmd_ff;
   logic [2:0] hi_ff;
   wire logic  tk = clk_en & frame_active & byte_valid;
   wire logic  cmd = tk & in_cmd_ff & synced_ff;
   wire logic  is_mem = (byte_in[7:6] == 2'h0) & byte_in[3];

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         in_cmd_ff <= 1'b1;
      end else if (clk_en && !frame_active) begin
         in_cmd_ff <= 1'b1;
      end else if (cmd && is_mem) begin
         in_cmd_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hi_ff <= 3'h0;
      end else if (cmd) begin
         hi_ff <= byte_in[2:0];
      end
   end

   // ************
   // Properties
   // ************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   property p_go(logic [7:0] c, rhcd_radio_t s);
      cmd && byte_in == c |=> radio_state_ff == s;
   endproperty : p_go

   a_go_off: assert property (p_go(GO_OFF_CMD, off_state))
      else $error("off code missed");
   a_go_idle: assert property (p_go(GO_IDLE_CMD, idle_state))
      else $error("idle code missed");
   a_go_rx: assert property (p_go(GO_RECEIVE_CMD, receive_state))
      else $error("receive code missed");
   a_go_tx: assert property (p_go(GO_TRANSMIT_CMD, transmit_state))
      else $error("transmit code missed");
   a_go_sleep: assert property (p_go(GO_SLEEP_CMD, sleep_state))
      else $error("sleep code missed");
   a_sync_gate: assert property (!synced_ff && tk
      && byte_in != SYNC_CMD
      |=> !synced_ff && radio_state_ff == $past(radio_state_ff))
      else $error("byte acted before sync");
   a_sync_take: assert property (!synced_ff && tk
      && byte_in == SYNC_CMD |=> synced_ff)
      else $error("sync byte not taken");
   a_full_reset: assert property (cmd && byte_in == FULL_RESET_CMD
      |=> full_reset_ff && !synced_ff && radio_state_ff == sleep_state)
      else $error("full reset wrong");
   a_image_gate: assert property (cmd && byte_in == IMAGE_CAL_CMD
      |=> image_cal_ff == ($past(resident_module) == 2'h1))
      else $error("image cal gating wrong");
   a_op0_module: assert property (cmd && byte_in == MODULE_OP0_CMD
      |=> encrypt_ff == ($past(resident_module) == 2'h2)
      && fec_encode_ff == ($past(resident_module) == 2'h3))
      else $error("shared code routed wrong");
   a_seq_write: assert property (cmd && byte_in[7:3] == SEQ_WRITE_PFX
      ##1 tk ##1 tk |=> mem_wr_ff && mem_wdata_ff == $past(byte_in)
      && mem_addr_ff == {hi_ff, $past(byte_in, 2)})
      else $error("seq write wrong");
   a_seq_read: assert property (cmd && byte_in[7:3] == SEQ_READ_PFX
      ##1 tk |=> mem_rd_ff && mem_addr_ff == {hi_ff, $past(byte_in)})
      else $error("seq read address wrong");
   a_scatter_wr: assert property (cmd
      && byte_in[7:3] == SCATTER_WR_PFX
      ##1 tk ##1 tk |=> mem_wr_ff && mem_wdata_ff == $past(byte_in)
      && mem_addr_ff == {hi_ff, $past(byte_in, 2)})
      else $error("scattered write wrong");
   a_read_reply: assert property (clk_en && mem_rvalid
      |=> reply_valid_ff && reply_byte_ff == $past(mem_rdata))
      else $error("read reply wrong");

   c_seq_wr: cover property (cmd && byte_in[7:3] == SEQ_WRITE_PFX);
   c_reply: cover property (reply_valid_ff);
   c_reset: cover property (full_reset_ff);
endmodule : rhcd_decoder_sva

bind rhcd_decoder rhcd_decoder_sva i_rhcd_decoder_sva (.*);
`default_nettype wire

// ---- tb/rhcd_mem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module rhcd_mem_model
   import rhcd_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   // Latency select
   input  wire logic              slow,
   // Memory port
   input  wire logic              mem_rd_ff,
   input  wire logic [ADDR_W-1:0] mem_addr_ff,
   output logic [7:0]             mem_rdata,
   output logic                   mem_rvalid
);
   // ************
   // Read pipeline
   // ************
   // Latency fixed per frame; a change mid-stream could overwrite entries
   logic [3:0] vld_ff;
   logic [7:0] dat_ff [4];
   logic [7:0] last_ff;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         vld_ff  <= 4'h0;
         last_ff <= 8'h00;
      end else begin
         vld_ff <= {1'b0, vld_ff[3:1]};
         for (int j = 0; j < 3; j++) begin
            dat_ff[j] <= dat_ff[j+1];
         end
         if (mem_rd_ff) begin
            vld_ff[slow ? 3 : 0] <= 1'b1;
            dat_ff[slow ? 3 : 0] <= mem_addr_ff[7:0] ^
               {mem_addr_ff[10:8], 5'h0d};
         end
         if (vld_ff[0]) begin
            last_ff <= dat_ff[0];
         end
      end
   end

   // Idle bus shows the inverse of the last byte, never a held value
   assign mem_rvalid = vld_ff[0];
   assign mem_rdata  = vld_ff[0] ? dat_ff[0] : ~last_ff;
endmodule : rhcd_mem_model
`default_nettype wire

// ---- tb/rhcd_decoder_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module rhcd_decoder_test;
   import rhcd_pkg::*;
   // ************
   // Signals
   // ************
   logic              sys_clk, sys_rst, clk_en, frame_active, byte_valid;
   logic              slow, reply_valid_ff, mem_wr_ff, mem_rd_ff;
   logic              mem_rvalid, synced_ff;
   logic [7:0]        byte_in, reply_byte_ff, mem_wdata_ff, mem_rdata;
   logic [1:0]        resident_module;
   logic [ADDR_W-1:0] mem_addr_ff, a;
   rhcd_radio_t       radio_state_ff;
   logic              apply_config_ff, signal_strength_ff, if_filter_cal_ff;
   logic              image_cal_ff, full_reset_ff, load_init_ff;
   logic              load_done_ff, encrypt_ff, decrypt_ff, decrypt_init_ff;
   logic              fec_encode_init_ff, fec_encode_ff, fec_decode_ff;
   logic [23:0]       exp_q [$];
   logic [22:0]       stab [15];
   logic [7:0]        base [4] = '{8'h08, 8'h09, 8'h0b, 8'h0e};
   logic [7:0]        go_c [5] = '{8'hb0, 8'hb1, 8'hb2, 8'hb5, 8'hba};
   logic [7:0]        lo, d, c;
   integer            seed;
   int                num_errors, checked, i, k;
   wire logic [12:0]  strb = {apply_config_ff, signal_strength_ff,
      if_filter_cal_ff, image_cal_ff, full_reset_ff, load_init_ff,
      load_done_ff, encrypt_ff, decrypt_ff, decrypt_init_ff,
      fec_encode_init_ff, fec_encode_ff, fec_decode_ff};

   rhcd_decoder i_rhcd_decoder (.sys_clk, .sys_rst, .clk_en, .frame_active,
      .byte_valid, .byte_in, .reply_byte_ff, .reply_valid_ff, .mem_addr_ff,
      .mem_wdata_ff, .mem_wr_ff, .mem_rd_ff, .mem_rdata, .mem_rvalid,
      .resident_module, .radio_state_ff, .synced_ff, .apply_config_ff,
      .signal_strength_ff, .if_filter_cal_ff, .image_cal_ff, .full_reset_ff,
      .load_init_ff, .load_done_ff, .encrypt_ff, .decrypt_ff,
      .decrypt_init_ff, .fec_encode_init_ff, .fec_encode_ff, .fec_decode_ff);
   rhcd_mem_model i_rhcd_mem_model (.sys_clk, .sys_rst, .slow, .mem_rd_ff,
      .mem_addr_ff, .mem_rdata, .mem_rvalid);

   always #2 sys_clk = ~sys_clk;

   // ************
   // Tasks
   // ************
   function automatic logic [7:0] mem_pat(input logic [ADDR_W-1:0] x);
      return x[7:0] ^ {x[10:8], 5'h0d};
   endfunction : mem_pat

   task automatic check(input logic [23:0] seen, input logic [23:0] want);
      checked++;
      if (seen !== want) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic note_cmp(input logic [23:0] seen);
      logic [23:0] want;
      want = 24'hffffff;
      if (exp_q.size() > 0) want = exp_q.pop_front();
      check(seen, want);
   endtask : note_cmp

   task automatic chk_state(input rhcd_radio_t s, input logic y);
      check(24'(radio_state_ff), 24'(s));
      check(24'(synced_ff), 24'(y));
   endtask : chk_state

   task automatic tx(input logic [7:0] b);
      @(negedge sys_clk);
      frame_active = 1'b1;
      byte_valid = 1'b1;
      byte_in = b;
   endtask : tx

   task automatic gap(input int n);
      repeat (n) begin
         @(negedge sys_clk);
         byte_valid = 1'b0;
         frame_active = 1'b0;
         byte_in = ~byte_in;
      end
   endtask : gap

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   // ************
   // Result watcher
   // ************
   always @(negedge sys_clk) begin
      if (sys_rst === 1'b0) begin
         if (mem_wr_ff !== 1'b0) note_cmp({5'h02, mem_addr_ff, mem_wdata_ff});
         if (reply_valid_ff !== 1'b0) note_cmp({16'h2000, reply_byte_ff});
         if (strb !== 13'h0) note_cmp({11'h180, strb});
      end
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      tally_and_finish();
   end

   // ************
   // Main sequence
   // ************
   initial begin
      seed = 32'hb6dfc838;
      sys_clk = 1'b0;
      sys_rst = 1'b1;
      clk_en = 1'b1;
      frame_active = 1'b0;
      byte_valid = 1'b0;
      byte_in = 8'hff;
      resident_module = 2'h0;
      slow = 1'b0;
      stab = '{{8'hbb, 2'h0, 13'h1000}, {8'hbc, 2'h0, 13'h0800},
         {8'hbe, 2'h0, 13'h0400}, {8'hbf, 2'h0, 13'h0080},
         {8'hc7, 2'h0, 13'h0040}, {8'hbd, 2'h1, 13'h0200},
         {8'hbd, 2'h0, 13'h0000}, {8'hd0, 2'h2, 13'h0020},
         {8'hd1, 2'h2, 13'h0008}, {8'hd2, 2'h2, 13'h0010},
         {8'hd0, 2'h3, 13'h0002}, {8'hd1, 2'h3, 13'h0004},
         {8'hd2, 2'h3, 13'h0001}, {8'hd0, 2'h0, 13'h0000},
         {8'hd2, 2'h1, 13'h0000}};
      repeat (10) @(negedge sys_clk);
      sys_rst = 1'b0;
      tx(GO_IDLE_CMD);
      gap(3);
      chk_state(sleep_state, 1'b0);
      tx(SYNC_CMD);
      gap(3);
      chk_state(sleep_state, 1'b1);
      $display("test sync done");
      for (i = 0; i < 5; i++) begin
         tx(go_c[i]);
         tx(8'h77);
         tx(NO_OP_BYTE);
         gap(2);
         chk_state(rhcd_radio_t'(3'(i)), 1'b1);
      end
      $display("test states done");
      for (i = 0; i < 15; i++) begin
         {c, resident_module} = stab[i][22:13];
         if (|stab[i][12:0]) exp_q.push_back({11'h180, stab[i][12:0]});
         tx(c);
         gap(3);
      end
      $display("test strobes done");
      for (i = 0; i < 4; i++) begin
         lo = 8'($random(seed));
         c = base[i] | 8'h10;
         a = {c[2:0], lo};
         tx(c);
         tx(lo);
         for (k = 1; k <= 3; k++) begin
            d = 8'($random(seed));
            tx(d);
            exp_q.push_back({5'h02, a + 11'(k - 1), d});
         end
         gap(4);
      end
      for (i = 0; i < 3; i++) begin
         slow = i[0];
         lo = 8'($random(seed));
         c = base[i] | 8'h30;
         a = {c[2:0], lo};
         for (k = 0; k < 3; k++)
            exp_q.push_back({16'h2000, mem_pat(a + 11'(k))});
         tx(c);
         tx(lo);
         tx(NO_OP_BYTE);
         tx(NO_OP_BYTE);
         gap(8);
      end
      $display("test sequential done");
      for (i = 0; i < 3; i++) begin
         slow = !i[0];
         c = base[i];
         tx(c);
         for (k = 0; k < 2; k++) begin
            lo = 8'($random(seed));
            d = 8'($random(seed));
            tx(lo);
            tx(d);
            exp_q.push_back({5'h02, c[2:0], lo, d});
         end
         gap(4);
         tx(c | 8'h20);
         for (k = 0; k < 2; k++) begin
            lo = 8'($random(seed));
            tx(lo);
            tx(NO_OP_BYTE);
            exp_q.push_back({16'h2000, mem_pat({c[2:0], lo})});
         end
         gap(8);
      end
      $display("test scattered done");
      tx(8'h18);
      tx(8'h40);
      gap(2);
      tx(GO_RECEIVE_CMD);
      gap(2);
      chk_state(receive_state, 1'b1);
      tx(GO_TRANSMIT_CMD);
      clk_en = 1'b0;
      gap(3);
      clk_en = 1'b1;
      chk_state(receive_state, 1'b1);
      exp_q.push_back({11'h180, 13'h0100});
      tx(FULL_RESET_CMD);
      gap(3);
      chk_state(sleep_state, 1'b0);
      tx(GO_IDLE_CMD);
      gap(3);
      chk_state(sleep_state, 1'b0);
      check(24'(exp_q.size()), 24'h0);
      $display("test reset done");
      tally_and_finish();
   end
endmodule : rhcd_decoder_test
`default_nettype wire
